// ### hw/mcu_reset_sequencer.sv
`timescale 1ns/1ps
// How it works
// - after pin release wait 20 cycles single-chip, 22 in processor mode.
// - watchdog or oscillator fault reset drives the reset pin low.
// - ram keeps its contents over reset, working registers a, b cleared.
// - other control and status bits clear to zero on power-up; warm reset keeps mode request and irq mask, sets irq status.
// - mode bits read 1 only after warm reset in processor mode.
// - power-up sets power-on flag; warm reset flags show the cause.
// - port control sets reset to ones in processor warm reset, else 0.
// - transmitter, converter and capture ready flags set on any reset.
module mcu_reset_sequencer #(
   parameter int RAM_DEPTH = 16
) (
   // clock and power-up reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // reset pin, open drain
   input wire logic reset_pin_in_n,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   // mode pin and fault sources
   input wire logic mode_pin,
   input wire logic watchdog_overflow,
   input wire logic oscillator_fault,
   // to the core
   output logic core_reset_n,
   output logic fetch_start,
   output logic proc_mode,
   output logic [7:0] work_reg_a,
   output logic [7:0] work_reg_b,
   output logic [7:0] port_control_set_one,
   output logic [7:0] port_control_set_two,
   // interrupt
   output logic irq
);
   import rst_seq_pkg::*;

   localparam int RAM_AW = $clog2(RAM_DEPTH);
   localparam logic [4:0] DELAY_SINGLE = 5'(FETCH_DELAY_SINGLE);
   localparam logic [4:0] DELAY_PROC = 5'(FETCH_DELAY_PROC);
   localparam logic [4:0] DRIVE_LEN = 5'(PIN_DRIVE_CYCLES);

   initial begin
      if (RAM_DEPTH * 4 > int'(RAM_SPAN)) $error("ram depth exceeds window");
   end

   typedef enum logic [1:0] {st_hold, st_drive, st_count, st_run} seq_t;
   seq_t state;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // apb decode
   logic wr_acc;
   logic rd_acc;
   logic ram_hit;
   assign pready = 1'b1;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign ram_hit = (paddr >= OFS_RAM) && (paddr < OFS_RAM + RAM_SPAN);

   // pin synchroniser: three stages, change counts when 2 and 3 agree
   logic [2:0] pin_sync;
   logic pin_high;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync <= 3'h0;
      end else begin
         pin_sync <= {pin_sync[1:0], reset_pin_in_n};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_high <= 1'b0;
      end else if (pin_sync[2] == pin_sync[1]) begin
         pin_high <= pin_sync[1];
      end
   end

   logic [2:0] mode_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_sync <= 3'h0;
      end else begin
         mode_sync <= {mode_sync[1:0], mode_pin};
      end
   end
   // strap level counts once the last two stages agree
   logic mode_level;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_level <= 1'b0;
      end else if (mode_sync[2] == mode_sync[1]) begin
         mode_level <= mode_sync[2];
      end
   end

   logic wd_evt;
   logic osc_evt;
   logic [1:0] wd_sync;
   logic [1:0] osc_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_sync <= 2'h0;
         osc_sync <= 2'h0;
      end else begin
         wd_sync <= {wd_sync[0], watchdog_overflow};
         osc_sync <= {osc_sync[0], oscillator_fault};
      end
   end
   assign wd_evt = wd_sync[1] && state == st_run;
   assign osc_evt = osc_sync[1] && state == st_run;

   // sequencer
   logic [4:0] count;
   logic warm_pending;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_hold;
         count <= 5'h00;
      end else begin
         case (state)
            st_hold: begin
               count <= 5'h00;
               if (pin_high) begin
                  state <= st_count;
               end
            end
            st_drive: begin
               count <= count + 5'h01;
               if (count == DRIVE_LEN - 5'h01) begin
                  state <= st_hold;
               end
            end
            st_count: begin
               count <= count + 5'h01;
               if (!pin_high) begin
                  state <= st_hold;
               end else if (count == (proc_mode ? DELAY_PROC : DELAY_SINGLE)
                            - 5'h01) begin
                  state <= st_run;
               end
            end
            st_run: begin
               count <= 5'h00;
               if (osc_evt) begin
                  state <= st_drive;
               end else if (wd_evt) begin
                  state <= st_drive;
               end else if (!pin_high) begin
                  state <= st_hold;
               end
            end
            default: state <= st_hold;
         endcase
      end
   end
   // one-cycle strobe on entry to any warm reset
   assign warm_pending = (state == st_run) && (osc_evt || wd_evt || !pin_high);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_start <= 1'b0;
      end else begin
         fetch_start <= state == st_count && pin_high &&
            count == (proc_mode ? DELAY_PROC : DELAY_SINGLE) - 5'h01;
      end
   end

   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = (state == st_drive);
   assign core_reset_n = (state == st_run);

   // control register: bit 0 requests processor mode for next warm reset
   logic mode_req;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_req <= 1'b0;
      end else if (wr_acc && hit(paddr, OFS_CTRL)) begin
         mode_req <= pwdata[0];
      end
   end

   // system control bits, latched on entry to reset
   logic [4:0] sysctl;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sysctl <= '0;
         sysctl[B_POWER_ON] <= 1'b1;
      end else if (warm_pending) begin
         sysctl[B_MODE_SEL] <= mode_req && mode_level;
         sysctl[B_MODE_PIN] <= mode_req && mode_level;
         sysctl[B_POWER_ON] <= 1'b0;
         sysctl[B_OSC_FAIL] <= osc_evt;
         sysctl[B_WD_OVF] <= wd_evt && !osc_evt;
      end
   end
   assign proc_mode = sysctl[B_MODE_SEL];

   // port control and peripheral ready bits
   logic [3:0] periph;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_control_set_one <= PORT_ALL_ZEROS;
         port_control_set_two <= PORT_ALL_ZEROS;
         periph <= PERIPH_READY_RESET;
      end else if (state != st_run) begin
         port_control_set_one <= proc_mode ? PORT_ALL_ONES
                                           : PORT_ALL_ZEROS;
         port_control_set_two <= proc_mode ? PORT_ALL_ONES : PORT_ALL_ZEROS;
         periph <= PERIPH_READY_RESET;
      end else if (wr_acc && hit(paddr, OFS_PORTCTL)) begin
         port_control_set_one <= pwdata[7:0];
         port_control_set_two <= pwdata[15:8];
      end else if (wr_acc && hit(paddr, OFS_PERIPH)) begin
         periph <= pwdata[3:0];
      end
   end

   // working registers a and b are lost on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         work_reg_a <= 8'h00;
         work_reg_b <= 8'h00;
      end else if (state != st_run) begin
         work_reg_a <= 8'h00;
         work_reg_b <= 8'h00;
      end else if (wr_acc && hit(paddr, OFS_CTRL)) begin
         work_reg_a <= pwdata[15:8];
         work_reg_b <= pwdata[23:16];
      end
   end

   // interrupts: write one to clear, set wins
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] irq_set;
   assign irq_set = {fetch_start, warm_pending};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 2'h0;
      end else begin
         irq_stat <= irq_set | (irq_stat &
            ~((wr_acc && hit(paddr, OFS_IRQ_STAT)) ? pwdata[1:0] : 2'h0));
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask <= 2'h0;
      end else if (wr_acc && hit(paddr, OFS_IRQ_MASK)) begin
         irq_mask <= pwdata[1:0];
      end
   end
   assign irq = |(irq_stat & irq_mask);

   // ram window, contents never reset
   logic [7:0] ram_rd;
   ram_store #(.WIDTH(8), .DEPTH(RAM_DEPTH)) u_ram (
      .pclk(pclk),
      .wr_en(wr_acc && ram_hit),
      .wr_addr(RAM_AW'(paddr[7:2])),
      .wr_data(pwdata[7:0]),
      .rd_addr(RAM_AW'(paddr[7:2])),
      .rd_data(ram_rd)
   );

   // read data registered in setup phase
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = UNMAPPED_READ;
      case (paddr)
         OFS_CTRL: next_rdata = {8'h00, work_reg_b, work_reg_a, 7'h00,
                                 mode_req};
         OFS_STATUS: next_rdata = {27'h0, pin_high, mode_level,
                                   core_reset_n, 2'(state)};
         OFS_SYSCTL: next_rdata = {27'h0, sysctl};
         OFS_PORTCTL: next_rdata = {16'h0, port_control_set_two,
                                    port_control_set_one};
         OFS_PERIPH: next_rdata = {28'h0, periph};
         OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
         OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
         default: next_rdata = UNMAPPED_READ;
      endcase
   end
   logic ram_rd_sel;
   logic [31:0] rdata_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
         ram_rd_sel <= 1'b0;
      end else if (rd_acc) begin
         rdata_q <= next_rdata;
         ram_rd_sel <= ram_hit;
      end
   end
   assign prdata = ram_rd_sel ? {24'h0, ram_rd} : rdata_q;
   assign pslverr = 1'b0;
endmodule : mcu_reset_sequencer

// ### hw/rst_seq_pkg.sv
package rst_seq_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_SYSCTL = 8'h08;
   localparam logic [7:0] OFS_PORTCTL = 8'h0C;
   localparam logic [7:0] OFS_PERIPH = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_RAM = 8'h40;
   localparam logic [7:0] RAM_SPAN = 8'h40;
   // system control bit positions
   localparam int B_MODE_SEL = 0;
   localparam int B_MODE_PIN = 1;
   localparam int B_POWER_ON = 2;
   localparam int B_OSC_FAIL = 3;
   localparam int B_WD_OVF = 4;
   // peripheral ready bit positions
   localparam int B_TX_EMPTY = 0;
   localparam int B_TX_READY = 1;
   localparam int B_CONV_READY = 2;
   localparam int B_CAPT_TX_READY = 3;
   // interrupt event bit positions
   localparam int B_EV_RESET = 0;
   localparam int B_EV_FETCH = 1;
   // fetch delays in system cycles
   localparam int FETCH_DELAY_SINGLE = 20;
   localparam int FETCH_DELAY_PROC = 22;
   // how long the device drives the reset pin low
   localparam int PIN_DRIVE_CYCLES = 16;
   localparam logic [7:0] PORT_ALL_ONES = 8'hFF;
   localparam logic [7:0] PORT_ALL_ZEROS = 8'h00;
   localparam logic [3:0] PERIPH_READY_RESET = 4'hF;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   typedef enum logic [1:0] {
      cause_none, cause_power, cause_watchdog, cause_osc
   } cause_t;
endpackage : rst_seq_pkg

// ### hw/ram_store.sv
`timescale 1ns/1ps
module ram_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock
   input wire logic pclk,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH < 4) $error("ram_store: depth too small");
   end

   // no reset: contents survive every reset
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge pclk) begin
      rd_data <= mem[rd_addr];
   end
endmodule : ram_store

// ### test/rst_seq_checker_assertions.sv
`timescale 1ns/1ps
module rst_seq_checker (
   // watched ports
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reset_pin_in_n,
   input wire logic reset_pin_oe,
   input wire logic reset_pin_out,
   input wire logic watchdog_overflow,
   input wire logic core_reset_n,
   input wire logic fetch_start,
   input wire logic proc_mode,
   input wire logic [7:0] work_reg_a,
   input wire logic [7:0] work_reg_b,
   input wire logic [7:0] port_control_set_one,
   input wire logic [7:0] port_control_set_two
);
   logic [7:0] since;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // cycles since the pin was last seen low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) since <= 8'h00;
      else if (!reset_pin_in_n) since <= 8'h00;
      else if (since != 8'hFF) since <= since + 8'h01;
   end
   sequence drive_8;
      reset_pin_oe [*8];
   endsequence
   AST_FETCH_DELAY: assert property (fetch_start |-> (proc_mode ?
      since inside {[23:28]} : since inside {[21:26]}))
      else $error("fetch delay wrong");
   AST_CORE_GO: assert property (fetch_start |->
      core_reset_n && !$past(core_reset_n)) else $error("core start wrong");
   AST_PIN_PULL: assert property ($rose(watchdog_overflow) &&
      core_reset_n |-> ##[1:4] reset_pin_oe) else $error("pin not pulled");
   AST_PIN_LEN: assert property ($rose(reset_pin_oe) |->
      drive_8 ##1 drive_8 ##1 !reset_pin_oe) else $error("drive length");
   AST_PIN_LOW: assert property (reset_pin_oe |-> !reset_pin_out)
      else $error("pin driven high");
   AST_SYNC_HOLD: assert property ($rose(reset_pin_in_n) |->
      !core_reset_n [*8]) else $error("core left reset early");
   AST_WORK_CLR: assert property (fetch_start |->
      work_reg_a == 8'h00 && work_reg_b == 8'h00) else $error("work regs");
   AST_PORT_RST: assert property (fetch_start |->
      port_control_set_one == {8{proc_mode}} &&
      port_control_set_two == {8{proc_mode}}) else $error("port reset");
endmodule : rst_seq_checker
bind mcu_reset_sequencer rst_seq_checker i_chk (.pclk(pclk),
   .presetn(presetn), .reset_pin_in_n(reset_pin_in_n),
   .reset_pin_oe(reset_pin_oe), .reset_pin_out(reset_pin_out),
   .watchdog_overflow(watchdog_overflow), .core_reset_n(core_reset_n),
   .fetch_start(fetch_start), .proc_mode(proc_mode),
   .work_reg_a(work_reg_a), .work_reg_b(work_reg_b),
   .port_control_set_one(port_control_set_one),
   .port_control_set_two(port_control_set_two));

// ### test/reset_supervisor.sv
`timescale 1ns/1ps
module reset_supervisor (
   // bench command
   input wire logic hold_low,
   // device side of the open-drain pin
   input wire logic device_oe,
   input wire logic device_out,
   output logic pin_level
);
   // pulls low only; the pull-up gives the high level
   assign pin_level = (hold_low || (device_oe && !device_out)) ?
      1'b0 : 1'b1;
endmodule : reset_supervisor

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import rst_seq_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, pin, oe, pout, irq, core_n, fetch, proc;
   logic hold_low = 1'b1, mode_pin = 1'b0, wdog = 1'b0, oscf = 1'b0;
   logic [7:0] wa, wb, p1, p2, ra, a, b, rb;
   logic [15:0] pv;
   logic pm;
   int mismatches = 0, checked = 0, i, k;
   initial begin
      forever #4 pclk = ~pclk;
   end
   mcu_reset_sequencer i_mcu_reset_sequencer (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .reset_pin_in_n(pin), .reset_pin_out(pout),
      .reset_pin_oe(oe), .mode_pin(mode_pin), .watchdog_overflow(wdog),
      .oscillator_fault(oscf), .core_reset_n(core_n), .fetch_start(fetch),
      .proc_mode(proc), .work_reg_a(wa), .work_reg_b(wb),
      .port_control_set_one(p1), .port_control_set_two(p2), .irq(irq));
   reset_supervisor i_reset_supervisor (.hold_low(hold_low),
      .device_oe(oe), .device_out(pout), .pin_level(pin));
   task check(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task stop_test;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   task rchk(input string what, input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      check(what, rd, e);
      check("slverr", 32'(pslverr), 0);
      check("ready", 32'(pready), 1);
   endtask : rchk
   function automatic logic [31:0] exp_sys(input logic wd, osc, m);
      return {27'h0, wd, osc, 1'b0, m, m};
   endfunction : exp_sys
   // counts negedges from pin release to the fetch pulse
   task wait_fetch(input logic m);
      int d;
      d = m ? FETCH_DELAY_PROC : FETCH_DELAY_SINGLE;
      for (k = 0; k < 100 && pin !== 1'b1; k++) @(negedge pclk);
      for (k = 0; k < 100 && fetch !== 1'b1; k++) @(negedge pclk);
      check("fetch delay", 32'(k >= d + 2 && k <= d + 5), 1);
   endtask : wait_fetch
   task after_reset(input logic [31:0] sys, input logic m);
      rchk("sysctl", OFS_SYSCTL, sys);
      rchk("periph", OFS_PERIPH, 32'(PERIPH_READY_RESET));
      check("port one", 32'(p1), 32'({8{m}}));
      check("port two", 32'(p2), 32'({8{m}}));
      check("work", {wa, wb}, 0);
      check("proc", 32'(proc), 32'(m));
   endtask : after_reset
   initial begin
      void'($urandom(61570));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      hold_low <= 1'b0;
      wait_fetch(1'b0);
      after_reset(32'h4, 1'b0);
      rchk("mask", OFS_IRQ_MASK, 0);
      rchk("ctrl", OFS_CTRL, 0);
      rchk("unmapped", 8'h30, UNMAPPED_READ);
      for (i = 0; i < 8; i++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         rb = 8'($urandom);
         pv = 16'($urandom);
         ra = OFS_RAM + 8'(i * 4);
         pm = i[1] & i[2];
         @(posedge pclk);
         mode_pin <= i[2];
         apb(1'b1, OFS_CTRL, {8'h0, b, a, 7'h0, i[1]});
         check("work set", {wa, wb}, {a, b});
         apb(1'b1, OFS_PORTCTL, 32'(pv));
         check("port set", {p2, p1}, pv);
         apb(1'b1, OFS_PERIPH, 32'h0);
         apb(1'b1, ra, 32'(rb));
         apb(1'b1, OFS_IRQ_STAT, 32'h3);
         check("irq off", 32'(irq), 0);
         @(posedge pclk);
         if (i[0]) oscf <= 1'b1;
         else wdog <= 1'b1;
         for (k = 0; k < 20 && oe !== 1'b1; k++) @(negedge pclk);
         check("pin low", 32'(pin), 0);
         @(posedge pclk);
         oscf <= 1'b0;
         wdog <= 1'b0;
         wait_fetch(pm);
         after_reset(exp_sys(!i[0], i[0], pm), pm);
         rchk("ram", ra, 32'(rb));
         rchk("irq stat", OFS_IRQ_STAT, 32'h3);
         apb(1'b1, OFS_IRQ_MASK, 32'h3);
         check("irq on", 32'(irq), 1);
         apb(1'b1, OFS_IRQ_MASK, 32'h0);
         check("irq masked", 32'(irq), 0);
         apb(1'b1, OFS_IRQ_STAT, 32'h3);
         rchk("irq clear", OFS_IRQ_STAT, 32'h0);
      end
      stop_test;
   end
   initial begin
      #100000;
      mismatches++;
      stop_test;
   end
endmodule : testbench
